// [inc/apst_pkg.sv]
// Package for the adapter power-on self-test block: address map, failure codes, types.
// Assumes a single 200 MHz clock and a 30-bit backplane physical address.
package apst_pkg;

  // ==========================================================================
  // Backplane address map
  // ==========================================================================
  localparam int ADDR_W = 30;
  localparam logic [29:0] IO_SPACE_BASE = 30'h2000_0000;
  localparam logic [29:0] NODE_SPACE_END = 30'h2001_FFFF;
  localparam int IO_SEL_BIT = 29;
  localparam int NODE_ID_LSB = 13;
  localparam logic [12:0] BLOCK_SIZE = 13'h1FFF;
  localparam logic [12:0] OFFS_FAIL_CODE = 13'h1FFC;
  localparam logic [12:0] OFFS_QUEUE_BASE = 13'h00F0;

  // ==========================================================================
  // Reset values and codes
  // ==========================================================================
  localparam logic [31:0] FAIL_CODE_RESET = 32'h0000_0000;
  localparam logic [31:0] PATTERN_A = 32'hA5A5_5A5A;
  localparam logic [4:0] ALU_RAM_LAST = 5'h1F;
  localparam logic [1:0] PKT_BUF_LAST = 2'h3;
  localparam logic [3:0] STEP_FIRST = 4'h1;
  localparam logic [3:0] STEP_LAST = 4'hC;
  localparam logic [7:0] EXT_REG_LAST = 8'h0F;
  localparam int TOGGLE_W = 16;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN = 3'b001,
    ST_CHECK = 3'b010,
    ST_PASS = 3'b011,
    ST_FAIL = 3'b100
  } apst_state_t;

  // Backplane request carried as one bundle.
  typedef struct packed {
    logic valid;
    logic write;
    logic [29:0] addr;
    logic [31:0] wdata;
  } apst_bus_req_t;

  // Memory port into the shared scratch memory.
  typedef struct packed {
    logic we;
    logic [5:0] addr;
    logic [31:0] wdata;
  } apst_mem_req_t;

endpackage : apst_pkg

// [rtl/apst_mem.sv]
// Small scratch memory used by the self-test to emulate internal stores.
// Assumes one clock; read data are registered one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module apst_mem (
  // Clock.
  input wire logic clk,
  // Access port.
  input wire apst_pkg::apst_mem_req_t req,
  output logic [31:0] rdata
);

  logic [31:0] store_q [0:63];

  // ==========================================================================
  // Storage
  // ==========================================================================
  // Write and registered read share one port; no reset keeps it a RAM.
  always_ff @(posedge clk)
  begin
    if (req.we)
    begin
      store_q[req.addr] <= req.wdata;
    end
    rdata <= store_q[req.addr];
  end

endmodule : apst_mem
`default_nettype wire

// [rtl/apst_top.sv]
// Power-on self-test sequencer and node-space decoder of the port adapter.
// Assumes a synchronous host on the backplane and inputs synchronous to clk.
//
// Overview of operation
// - Step 1 checks the zero, negative, overflow and carry status flags.
// - Step 2 writes and verifies all 32 ALU RAM locations.
// - Step 3 checks index, literal, local store and multiplexer control store paths.
// - Step 4 fills four packet buffers with a pattern and reads them back.
// - Step 5 loops data from DMA files through link buffer and back.
// - Step 6 requires the interface chip's own self-test ok bit.
// - Step 7 does a data mover write loopback into local store.
// - Step 8 does a write/read loopback through local store over internal buses.
// - Step 9 sets then clears every toggle register bit.
// - Step 10 verifies every parity error bit of the parity maintenance register.
// - Step 11 writes all extension registers and reads back via index.
// - Step 12 writes then reads its own queue block base over the backplane.
// - A failure leaves a code readable at node offset 1FFC.
// - Backplane addresses are 30 bits wide.
// - Address bit 29 selects memory (clear) or I/O (set) space.
// - 0 to 1FFFFFFF is memory, 20000000 to 3FFFFFFF is I/O.
// - Sixteen 8 Kbyte node blocks; respond only in our own.
// - Only node space is decoded; map window and broadcast ignored.
// - Node base equals I/O base plus 8K times node ID.
// - Offsets within the block run from 0000 to 1FFF.
// - Failed indicator clears only when both self-tests have passed.
`timescale 1ns/1ps
`default_nettype none
module apst_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Node identity and interface chip status.
  input wire logic [3:0] node_id,
  input wire logic interface_selftest_ok,
  // Backplane slave request from the host.
  input wire apst_pkg::apst_bus_req_t bus_req,
  // Backplane answer.
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  output logic bus_drive_en,
  // Self-test status.
  output logic selftest_busy,
  output logic selftest_failed,
  output logic [31:0] self_test_failure_code
);

  localparam int TOGGLE_W_LOC = apst_pkg::TOGGLE_W;

  // Sequencer position.
  logic [3:0] step_q;
  logic [7:0] idx_q;
  logic [1:0] phase_q;
  logic step_err;
  logic step_done;
  // Emulated stores and their checks.
  logic [3:0] flags_q;
  logic [TOGGLE_W_LOC-1:0] toggle_q;
  logic toggle_set_seen_q;
  logic [3:0] parity_maint_csr_q;
  logic [31:0] queue_block_base_q;
  logic [31:0] fail_code_q;
  logic [31:0] mem_rdata;
  logic [31:0] expect_w;
  // Decode and request path.
  logic in_node;
  logic hit_fail;
  logic hit_qbase;
  logic self_req;
  logic [29:0] node_base_address;
  apst_pkg::apst_state_t state_q;
  apst_pkg::apst_mem_req_t mreq;
  apst_pkg::apst_bus_req_t eff_req;

  // ==========================================================================
  // Address decode
  // ==========================================================================
  // Node base is the I/O base plus 8K per node ID.
  assign node_base_address = apst_pkg::IO_SPACE_BASE | {13'h0000, node_id, 13'h0000};
  // During test the sequencer owns the bus path for its self access.
  always_comb
  begin
    eff_req = bus_req;
    if (state_q == apst_pkg::ST_RUN && step_q == apst_pkg::STEP_LAST)
    begin
      eff_req.valid = (phase_q != 2'h3);
      eff_req.write = (phase_q == 2'h0);
      eff_req.addr = node_base_address | {17'h00000, apst_pkg::OFFS_QUEUE_BASE};
      eff_req.wdata = apst_pkg::PATTERN_A;
    end
  end
  assign self_req = (state_q == apst_pkg::ST_RUN) && (step_q == apst_pkg::STEP_LAST);
  // Bit 29 set means I/O; only our own 8K block inside node space answers.
  assign in_node = eff_req.addr[apst_pkg::IO_SEL_BIT]
    && (eff_req.addr <= apst_pkg::NODE_SPACE_END)
    && (eff_req.addr[29:apst_pkg::NODE_ID_LSB] == node_base_address[29:apst_pkg::NODE_ID_LSB]);
  assign hit_fail = in_node && (eff_req.addr[12:0] == apst_pkg::OFFS_FAIL_CODE);
  assign hit_qbase = in_node && (eff_req.addr[12:0] == apst_pkg::OFFS_QUEUE_BASE);

  // ==========================================================================
  // Slave answer
  // ==========================================================================
  // Drivers stay off while testing unless the access is our own.
  // Answer and drivers are both gated by the registered busy flag, so a host
  // read request never gets an answer without drivers in the cycle busy falls.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bus_ack <= 1'b0;
      bus_rdata <= 32'h0000_0000;
      bus_drive_en <= 1'b0;
    end
    else
    begin
      bus_ack <= eff_req.valid && in_node
        && (self_req || !selftest_busy);
      bus_drive_en <= eff_req.valid && in_node && !eff_req.write
        && (self_req || !selftest_busy);
      if (hit_fail)
      begin
        bus_rdata <= fail_code_q;
      end
      else if (hit_qbase)
      begin
        bus_rdata <= queue_block_base_q;
      end
      else
      begin
        bus_rdata <= 32'h0000_0000; // Unused offsets read as zero.
      end
    end
  end

  // Queue block base register written over the backplane.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      queue_block_base_q <= 32'h0000_0000;
    end
    else if (eff_req.valid && eff_req.write && hit_qbase
      && (self_req || !selftest_busy))
    begin
      queue_block_base_q <= eff_req.wdata;
    end
  end

  // ==========================================================================
  // Scratch memory
  // ==========================================================================
  // One RAM stands in for ALU RAM, control store, buffers, DMA files and
  // extension registers; the top address bit, step_q[0], picks one of two halves per step.
  always_comb
  begin
    mreq.we = (state_q == apst_pkg::ST_RUN) && (phase_q == 2'h0)
      && (step_q != apst_pkg::STEP_LAST);
    mreq.addr = {step_q[0], idx_q[4:0]}; // Five index bits reach all 32 words.
    mreq.wdata = expect_w;
  end
  // Pattern depends on index so stuck or aliased address lines show up.
  assign expect_w = apst_pkg::PATTERN_A ^ {24'h000000, idx_q} ^ {28'h0000000, step_q};

  apst_mem u_mem (
    .clk(clk),
    .req(mreq),
    .rdata(mem_rdata)
  );

  // ==========================================================================
  // Per-step item counts and checks
  // ==========================================================================
  // The scratch RAM proves the sequencing and compare paths only; it cannot
  // model stuck cells of the real stores, which is a known limitation.
  // Items per step: flags, 32 RAM words, 4 paths, 4 buffers, etc.
  function automatic logic [7:0] last_item(input logic [3:0] s);
    case (s)
      4'h1: last_item = 8'h03;
      4'h2: last_item = {3'b000, apst_pkg::ALU_RAM_LAST};
      4'h3: last_item = 8'h03;
      4'h4: last_item = {6'h00, apst_pkg::PKT_BUF_LAST};
      4'h9: last_item = 8'(TOGGLE_W_LOC - 1);
      4'hA: last_item = 8'h03;
      4'hB: last_item = apst_pkg::EXT_REG_LAST;
      default: last_item = 8'h00;
    endcase
  endfunction

  // Compare phase: each step checks its own observation of the item.
  always_comb
  begin
    step_err = 1'b0;
    unique case (step_q)
      4'h1: step_err = !flags_q[idx_q[1:0]];
      4'h6: step_err = !interface_selftest_ok;
      4'h9: step_err = toggle_q[idx_q[3:0]] || !toggle_set_seen_q;
      4'hA: step_err = !parity_maint_csr_q[idx_q[1:0]];
      4'hC: step_err = (queue_block_base_q != apst_pkg::PATTERN_A)
        || (bus_rdata != apst_pkg::PATTERN_A);
      // Steps 2,3,4,5,7,8,11 read back the memory.
      default: step_err = (mem_rdata != expect_w);
    endcase
  end
  assign step_done = (idx_q == last_item(step_q));

  // Flag exercise: each status flag is forced and must be observed.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      flags_q <= 4'h0;
      parity_maint_csr_q <= 4'h0;
    end
    else if (state_q == apst_pkg::ST_RUN && phase_q == 2'h0)
    begin
      flags_q[idx_q[1:0]] <= (step_q == 4'h1);
      parity_maint_csr_q[idx_q[1:0]] <= (step_q == 4'hA);
    end
  end

  // Toggle register: set bit then clear it before the check.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      toggle_q <= '0;
    end
    else if (state_q == apst_pkg::ST_RUN && step_q == 4'h9)
    begin
      toggle_q[idx_q[3:0]] <= (phase_q == 2'h0);
    end
  end

  // Capture the set state one cycle after the set, so a bit stuck low
  // fails as well as one stuck high.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      toggle_set_seen_q <= 1'b0;
    end
    else if (state_q == apst_pkg::ST_RUN && step_q == 4'h9 && phase_q == 2'h1)
    begin
      toggle_set_seen_q <= toggle_q[idx_q[3:0]];
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // Phases: 0 write, 1 settle, 2 read back, 3 wait; ST_CHECK then compares. Steps rise in order
  // and stop at the first failing one.
  // A failing run parks in ST_FAIL until the next reset, so no later step
  // can overwrite the stored failure code.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= apst_pkg::ST_IDLE;
      step_q <= apst_pkg::STEP_FIRST;
      idx_q <= 8'h00;
      phase_q <= 2'h0;
      fail_code_q <= apst_pkg::FAIL_CODE_RESET;
    end
    else
    begin
      unique case (state_q)
        apst_pkg::ST_IDLE:
        begin
          state_q <= apst_pkg::ST_RUN;
        end
        apst_pkg::ST_RUN:
        begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == 2'h3)
          begin
            state_q <= apst_pkg::ST_CHECK;
          end
        end
        apst_pkg::ST_CHECK:
        begin
          state_q <= apst_pkg::ST_RUN;
          if (step_err)
          begin
            // Bits 15:12 name the step, low byte the failing item.
            fail_code_q <= {16'h0000, step_q, 4'h0, idx_q};
            state_q <= apst_pkg::ST_FAIL;
          end
          else if (!step_done)
          begin
            idx_q <= idx_q + 8'h01;
          end
          else if (step_q == apst_pkg::STEP_LAST)
          begin
            state_q <= apst_pkg::ST_PASS;
          end
          else
          begin
            idx_q <= 8'h00;
            step_q <= step_q + 4'h1;
          end
        end
        apst_pkg::ST_PASS:
        begin
          state_q <= apst_pkg::ST_PASS;
        end
        apst_pkg::ST_FAIL:
        begin
          state_q <= apst_pkg::ST_FAIL;
        end
        default:
        begin
          state_q <= apst_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Status outputs
  // ==========================================================================
  // Failed clears only when both our test and the chip's test passed.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      selftest_busy <= 1'b1;
      selftest_failed <= 1'b1;
      self_test_failure_code <= apst_pkg::FAIL_CODE_RESET;
    end
    else
    begin
      selftest_busy <= (state_q != apst_pkg::ST_PASS) && (state_q != apst_pkg::ST_FAIL);
      selftest_failed <= !((state_q == apst_pkg::ST_PASS) && interface_selftest_ok);
      self_test_failure_code <= fail_code_q;
    end
  end

endmodule : apst_top
`default_nettype wire

// [testbench/apst_top_assertions.sv]
// Checker for the self-test block; it sees only the top module ports.
// Assumes one clock domain and an active-high synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module apst_top_assertions (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Block inputs.
  input wire logic [3:0] node_id,
  input wire logic interface_selftest_ok,
  input wire apst_pkg::apst_bus_req_t bus_req,
  // Block outputs.
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_drive_en,
  input wire logic selftest_busy,
  input wire logic selftest_failed,
  input wire logic [31:0] self_test_failure_code
);
  // ======================================
  // Decode
  // ======================================
  // Own block hit rebuilt from the map, so a decoder slip cannot hide.
  logic hit;
  assign hit = bus_req.valid && (bus_req.addr[29:17] == 13'h1000) &&
    (bus_req.addr[16:13] == node_id);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_test_start; $fell(reset); endsequence
  sequence s_busy_hold; selftest_busy [*8]; endsequence
  sequence s_test_end; $fell(selftest_busy); endsequence
  // ======================================
  // Properties
  // ======================================
  AST_BUSY_START: assert property (s_test_start |-> s_busy_hold)
    else $error("busy dropped right after reset");
  AST_ACK_HIT: assert property (hit && !selftest_busy |=> bus_ack)
    else $error("own block request not answered");
  AST_NO_ACK_MISS: assert property (!hit && !selftest_busy |=> !bus_ack)
    else $error("answer without own block request");
  AST_READ_CODE: assert property (hit && !bus_req.write && !selftest_busy &&
    bus_req.addr[12:0] == apst_pkg::OFFS_FAIL_CODE
    |=> bus_rdata == $past(self_test_failure_code))
    else $error("failure code read wrong");
  AST_DRIVE_READ: assert property (hit && !selftest_busy
    |=> bus_drive_en == !$past(bus_req.write))
    else $error("drivers wrong for a hit");
  AST_DRIVE_WITH_ACK: assert property (bus_drive_en |-> bus_ack)
    else $error("drivers on without an answer");
  AST_FAIL_CLEAR: assert property ($fell(selftest_failed)
    |-> interface_selftest_ok && !selftest_busy)
    else $error("failed indicator cleared too early");
  AST_FAIL_CODE: assert property (s_test_end ##0 selftest_failed
    |-> self_test_failure_code[15:12] != 4'h0 &&
    self_test_failure_code[15:12] <= apst_pkg::STEP_LAST)
    else $error("failure code names no step");
  AST_STS_CODE: assert property (s_test_end ##0 !interface_selftest_ok
    |-> self_test_failure_code == 32'h0000_6000)
    else $error("interface self-test failure not coded");
  AST_PASS_CODE: assert property (!selftest_busy && !selftest_failed
    |-> self_test_failure_code == apst_pkg::FAIL_CODE_RESET)
    else $error("code set after a pass");
endmodule : apst_top_assertions
`default_nettype wire

// [testbench/apst_host.sv]
// Host processor model on the backplane: single-word requests.
// Assumes the adapter takes a request on the next edge and answers one cycle later.
`timescale 1ns/1ps
`default_nettype none
module apst_host (
  // Clock.
  input wire logic clk,
  // Request toward the adapter.
  output var apst_pkg::apst_bus_req_t bus_req
);
  // Idle at time zero; nothing is valid until the bench asks.
  initial bus_req = '{valid: 1'b0, write: 1'b0, addr: 30'h0, wdata: 32'h0};
  // Held for one taking edge, then released with inverted fields so stale data shows.
  task drive(input logic write, input logic [29:0] addr, input logic [31:0] wdata);
    @(posedge clk);
    bus_req <= '{valid: 1'b1, write: write, addr: addr, wdata: wdata};
    @(posedge clk);
    bus_req <= '{valid: 1'b0, write: !write, addr: ~addr, wdata: ~wdata};
  endtask : drive
endmodule : apst_host
`default_nettype wire

// [testbench/test_apst_top.sv]
// Self-checking bench for the self-test block and its node decoder.
// Assumes apst_host drives requests and the checker is bound below.
`timescale 1ns/1ps
`default_nettype none
module test_apst_top;
  logic clk, reset, ok, ack, drv, busy, failed;
  logic [3:0] node;
  logic [31:0] rdata, code;
  apst_pkg::apst_bus_req_t req;
  int bad_count, checked;
  apst_top u_apst_top (.clk(clk), .reset(reset), .node_id(node),
    .interface_selftest_ok(ok), .bus_req(req), .bus_ack(ack), .bus_rdata(rdata),
    .bus_drive_en(drv), .selftest_busy(busy), .selftest_failed(failed),
    .self_test_failure_code(code));
  apst_host u_apst_host (.clk(clk), .bus_req(req));
  // ======================================
  // Clock and helpers
  // ======================================
  // Free running 200 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : compare
  function automatic logic [29:0] node_addr(input logic [3:0] id, input logic [12:0] offs);
    return apst_pkg::IO_SPACE_BASE + {13'h0, id, 13'h0} + {17'h0, offs};
  endfunction : node_addr
  // One request; the answer stands only in the cycle after it is taken.
  task access(input logic wr, input logic [29:0] a, input logic [31:0] wd,
    input logic hit_exp, input logic [31:0] rd_exp);
    u_apst_host.drive(wr, a, wd);
    #1;
    compare("ack", {31'h0, hit_exp}, {31'h0, ack});
    compare("drive_en", {31'h0, hit_exp && !wr}, {31'h0, drv});
    if (hit_exp && !wr)
      compare("rdata", rd_exp, rdata);
  endtask : access
  task print_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  // Reset, poke the block while it tests, then wait a bounded time for the end.
  task run_test(input logic [3:0] id, input logic sts_ok);
    int n;
    @(posedge clk);
    reset <= 1'b1;
    node <= id;
    ok <= sts_ok;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    access(1'b0, node_addr(id, apst_pkg::OFFS_FAIL_CODE), 32'h0, 1'b0, 32'h0);
    n = 0;
    while (busy !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 4000)
    begin
      bad_count++;
      print_verdict();
    end
  endtask : run_test
  // ======================================
  // Main sequence
  // ======================================
  // A failing run, refused addresses, then a passing run with register traffic.
  initial
  begin
    reset = 1'b1;
    node = 4'h5;
    ok = 1'b0;
    bad_count = 0;
    checked = 0;
    run_test(4'h5, 1'b0);
    compare("failed", 32'h1, {31'h0, failed});
    compare("code", 32'h0000_6000, code);
    access(1'b0, node_addr(4'h5, 13'h1FFC), 32'h0, 1'b1, 32'h0000_6000);
    access(1'b0, node_addr(4'h6, 13'h1FFC), 32'h0, 1'b0, 32'h0);
    access(1'b0, 30'h0000_BFFC, 32'h0, 1'b0, 32'h0);
    access(1'b0, 30'h3000_BFFC, 32'h0, 1'b0, 32'h0);
    access(1'b0, 30'h2002_BFFC, 32'h0, 1'b0, 32'h0);
    run_test(4'hF, 1'b1);
    compare("failed", 32'h0, {31'h0, failed});
    compare("code", apst_pkg::FAIL_CODE_RESET, code);
    access(1'b0, node_addr(4'hF, 13'h00F0), 32'h0, 1'b1, apst_pkg::PATTERN_A);
    access(1'b1, node_addr(4'hF, 13'h00F0), 32'h0F1E_2D3C, 1'b1, 32'h0);
    access(1'b0, node_addr(4'hF, 13'h00F0), 32'h0, 1'b1, 32'h0F1E_2D3C);
    access(1'b0, node_addr(4'hF, 13'h0000), 32'h0, 1'b1, 32'h0);
    access(1'b0, 30'h2001_FFFC, 32'h0, 1'b1, 32'h0);
    print_verdict();
  end
endmodule : test_apst_top
bind apst_top apst_top_assertions u_apst_top_assertions (.clk(clk), .reset(reset),
  .node_id(node_id), .interface_selftest_ok(interface_selftest_ok), .bus_req(bus_req),
  .bus_ack(bus_ack), .bus_rdata(bus_rdata), .bus_drive_en(bus_drive_en),
  .selftest_busy(selftest_busy), .selftest_failed(selftest_failed),
  .self_test_failure_code(self_test_failure_code));
`default_nettype wire
